/* File: wdr_wake_detach_reset_control.sv */
`default_nettype none
module wdr_wake_detach_reset_control #(
  parameter int PorCycles = wdr_pkg::POR_CYCLES
) (
  // Clock and reset.
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  // Register port.
  input  wire wdr_pkg::wdr_bus_req_type busReq,
  output var  logic [31:0]              readData,
  // Pins.
  input  wire wdr_pkg::wdr_pins_type    pins,
  // Core events.
  input  wire logic                     phyLinkUp,
  input  wire logic                     phyIrq,
  input  wire logic                     macGoodFrame,
  input  wire logic                     macWakeEvent,
  input  wire logic                     usbBusReset,
  input  wire logic                     usbSuspended,
  input  wire logic                     goodOutPacket,
  input  wire logic                     eepromDone,
  // Control outputs.
  output var  logic                     remoteWake,
  output var  logic                     usbAttach,
  output var  logic                     usbPllEnable,
  output var  logic                     suspendOnePower,
  output var  logic                     chipReset,
  output var  logic                     usbCoreReset,
  output var  logic                     tapReset,
  output var  logic                     eepromLoad,
  output var  logic                     eepromMacOnly,
  output var  logic                     phyPowerDown
);
  wdr_pkg::wdr_state_type state;
  wdr_pkg::wdr_state_type next_state;
  wdr_pkg::wdr_pins_type  syncPins;
  logic [wdr_pkg::COUNT_WIDTH-1:0] holdCount;
  logic        holdDone;
  logic        softPending;
  logic        liteRequest;
  logic        detachEnable;
  logic        detachStatus;
  logic        stickyBit;
  logic [1:0]  wakeSource;
  logic [1:0]  suspendSelect;
  logic        lanWakeEnable;
  logic        energyWakeEnable;
  logic [6:0]  pin7Config;
  logic        pin7Status;
  logic [1:0]  lanEnables;
  logic        pin7Source;
  logic        pin7SourceLast;
  logic        wakeCondition;
  logic        wakeLast;
  logic        regsClear;
  logic        hardClear;
  logic        wrHw;
  logic        wrPm;

  function automatic logic isWrite(input wdr_pkg::wdr_bus_req_type req, input logic [7:0] a);
    return req.write && (req.addr == a);
  endfunction

  wdr_pin_sync pinSync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pinIn   (pins),
    .pinOut  (syncPins)
  );

  assign holdDone = (holdCount == '0);
  assign wrHw = isWrite(busReq, wdr_pkg::ADDR_HW_CONFIG);
  assign wrPm = isWrite(busReq, wdr_pkg::ADDR_POWER_MGMT);
  assign hardClear = (state == wdr_pkg::ST_UNPOWERED) || (state == wdr_pkg::ST_POR_HOLD)
                     || (state == wdr_pkg::ST_EXT_HOLD);
  assign regsClear = hardClear || (state == wdr_pkg::ST_SOFT_HOLD)
                     || (state == wdr_pkg::ST_LITE_HOLD) || (state == wdr_pkg::ST_LOAD);

  always_comb begin
    if (pin7Config[wdr_pkg::P7_LINK_UP_WAKE] && pin7Config[wdr_pkg::P7_WAKE_ENABLE]) begin
      pin7Source = phyLinkUp;
    end else begin
      pin7Source = !pin7Config[wdr_pkg::P7_ENABLE_N] && !pin7Config[wdr_pkg::P7_DIRECTION]
                   && (syncPins.pin7 ^ pin7Config[wdr_pkg::P7_POLARITY]);
    end
  end

  always_comb begin
    next_state = state;
    if (state != wdr_pkg::ST_POR_HOLD && state != wdr_pkg::ST_UNPOWERED
        && !syncPins.busPowerDetect) begin
      next_state = wdr_pkg::ST_UNPOWERED;
    end else begin
      unique case (state)
        wdr_pkg::ST_UNPOWERED: begin
          if (syncPins.busPowerDetect) begin
            next_state = wdr_pkg::ST_LOAD;
          end
        end
        wdr_pkg::ST_POR_HOLD: begin
          if (holdDone) begin
            next_state = wdr_pkg::ST_LOAD;
          end
        end
        wdr_pkg::ST_EXT_HOLD: begin
          if (syncPins.externalResetN) begin
            next_state = wdr_pkg::ST_LOAD;
          end
        end
        wdr_pkg::ST_SOFT_HOLD: begin
          if (holdDone) begin
            next_state = wdr_pkg::ST_LOAD;
          end
        end
        wdr_pkg::ST_LITE_HOLD: begin
          if (holdDone) begin
            next_state = wdr_pkg::ST_RUN;
          end
        end
        wdr_pkg::ST_LOAD: begin
          if (!syncPins.externalResetN) begin
            next_state = wdr_pkg::ST_EXT_HOLD;
          end else if (eepromDone) begin
            next_state = wdr_pkg::ST_RUN;
          end
        end
        wdr_pkg::ST_RUN: begin
          if (!syncPins.externalResetN) begin
            next_state = wdr_pkg::ST_EXT_HOLD;
          end else if (usbBusReset) begin
            next_state = wdr_pkg::ST_LOAD;
          end else if (softPending && goodOutPacket) begin
            next_state = wdr_pkg::ST_SOFT_HOLD;
          end else if (liteRequest) begin
            next_state = wdr_pkg::ST_LITE_HOLD;
          end else if (detachEnable) begin
            next_state = wdr_pkg::ST_DETACHED;
          end
        end
        wdr_pkg::ST_DETACHED: begin
          if (!syncPins.externalResetN) begin
            next_state = wdr_pkg::ST_EXT_HOLD;
          end else if (phyLinkUp
                       || (pin7Config[wdr_pkg::P7_DETACH_WAKE] && pin7Source)) begin
            next_state = wdr_pkg::ST_RUN;
          end
        end
        default: next_state = wdr_pkg::ST_POR_HOLD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= wdr_pkg::ST_POR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      holdCount <= wdr_pkg::COUNT_WIDTH'(PorCycles - 1);
    end else if (next_state == wdr_pkg::ST_SOFT_HOLD && state != wdr_pkg::ST_SOFT_HOLD) begin
      holdCount <= wdr_pkg::COUNT_WIDTH'(wdr_pkg::SOFT_CYCLES - 1);
    end else if (next_state == wdr_pkg::ST_LITE_HOLD && state != wdr_pkg::ST_LITE_HOLD) begin
      holdCount <= wdr_pkg::COUNT_WIDTH'(wdr_pkg::LITE_CYCLES - 1);
    end else if (!holdDone) begin
      holdCount <= holdCount - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      softPending <= 1'b0;
    end else if (state == wdr_pkg::ST_SOFT_HOLD && holdDone) begin
      softPending <= 1'b0;
    end else if (hardClear) begin
      softPending <= 1'b0;
    end else if (wrHw && busReq.writeData[wdr_pkg::HW_SOFT_RESET]) begin
      softPending <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stickyBit <= 1'b0;
    end else if (hardClear) begin
      stickyBit <= 1'b0;
    end else if (wrHw && !regsClear) begin
      stickyBit <= busReq.writeData[wdr_pkg::HW_STICKY];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      liteRequest <= 1'b0;
    end else if (regsClear) begin
      liteRequest <= 1'b0;
    end else if (wrHw && busReq.writeData[wdr_pkg::HW_LITE_RESET]) begin
      liteRequest <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      detachEnable <= 1'b0;
      detachStatus <= 1'b0;
    end else if (hardClear) begin
      detachEnable <= 1'b0;
      detachStatus <= 1'b0;
    end else if (state == wdr_pkg::ST_DETACHED && next_state == wdr_pkg::ST_RUN) begin
      detachEnable <= 1'b0;
      detachStatus <= 1'b1;
    end else if (wrHw && state == wdr_pkg::ST_RUN) begin
      detachEnable <= busReq.writeData[wdr_pkg::HW_DETACH_ENABLE];
      if (busReq.writeData[wdr_pkg::HW_DETACH_STATUS]) begin
        detachStatus <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      suspendSelect    <= wdr_pkg::SUSPEND_RESET;
      lanWakeEnable    <= 1'b0;
      energyWakeEnable <= 1'b0;
      pin7Config       <= wdr_pkg::PIN7_CONFIG_RESET;
      lanEnables       <= wdr_pkg::LAN_ENABLES_RESET;
    end else if (regsClear) begin
      suspendSelect    <= wdr_pkg::SUSPEND_RESET;
      lanWakeEnable    <= 1'b0;
      energyWakeEnable <= 1'b0;
      pin7Config       <= wdr_pkg::PIN7_CONFIG_RESET;
      lanEnables       <= wdr_pkg::LAN_ENABLES_RESET;
    end else begin
      if (wrPm) begin
        suspendSelect    <= busReq.writeData[wdr_pkg::PM_SUSPEND_LO +: 2];
        lanWakeEnable    <= busReq.writeData[wdr_pkg::PM_LAN_WAKE];
        energyWakeEnable <= busReq.writeData[wdr_pkg::PM_ENERGY_WAKE];
      end
      if (isWrite(busReq, wdr_pkg::ADDR_PIN7_CONFIG)) begin
        pin7Config <= busReq.writeData[6:0];
      end
      if (isWrite(busReq, wdr_pkg::ADDR_WAKE_CONTROL)) begin
        lanEnables <= busReq.writeData[1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin7SourceLast <= 1'b0;
      pin7Status     <= 1'b0;
    end else begin
      pin7SourceLast <= pin7Source;
      if (pin7Source && !pin7SourceLast) begin
        pin7Status <= 1'b1;
      end else if (regsClear) begin
        pin7Status <= 1'b0;
      end else if (isWrite(busReq, wdr_pkg::ADDR_IRQ_STATUS)
                   && busReq.writeData[wdr_pkg::IRQ_PIN7]) begin
        pin7Status <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wakeSource <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 1) ? (macWakeEvent || (macGoodFrame && lanEnables == '0))
                     : (phyIrq && energyWakeEnable)) begin
          wakeSource[i] <= 1'b1;
        end else if (regsClear) begin
          wakeSource[i] <= 1'b0;
        end else if (wrPm && busReq.writeData[wdr_pkg::PM_WAKE_SRC_LO + i]) begin
          wakeSource[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    wakeCondition = pin7Config[wdr_pkg::P7_WAKE_ENABLE] && pin7Status;
    if (wakeSource[1] && (lanWakeEnable || lanEnables == '0)) begin
      wakeCondition = 1'b1;
    end
    if (wakeSource[0] && energyWakeEnable) begin
      wakeCondition = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wakeLast   <= 1'b0;
      remoteWake <= 1'b0;
    end else begin
      wakeLast   <= wakeCondition && usbSuspended;
      remoteWake <= wakeCondition && usbSuspended && !wakeLast;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      usbAttach       <= 1'b0;
      usbPllEnable    <= 1'b0;
      suspendOnePower <= 1'b0;
    end else begin
      usbAttach       <= (next_state == wdr_pkg::ST_RUN) || (next_state == wdr_pkg::ST_LOAD)
                         || (next_state == wdr_pkg::ST_LITE_HOLD);
      usbPllEnable    <= (next_state != wdr_pkg::ST_DETACHED)
                         && (next_state != wdr_pkg::ST_UNPOWERED);
      suspendOnePower <= (next_state == wdr_pkg::ST_DETACHED);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      chipReset    <= 1'b1;
      usbCoreReset <= 1'b1;
    end else begin
      chipReset    <= (next_state != wdr_pkg::ST_RUN) && (next_state != wdr_pkg::ST_LOAD)
                      && (next_state != wdr_pkg::ST_DETACHED);
      usbCoreReset <= (next_state == wdr_pkg::ST_UNPOWERED)
                      || (next_state == wdr_pkg::ST_POR_HOLD)
                      || (next_state == wdr_pkg::ST_EXT_HOLD)
                      || (next_state == wdr_pkg::ST_SOFT_HOLD);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      eepromLoad    <= 1'b0;
      eepromMacOnly <= 1'b0;
    end else begin
      eepromLoad <= (next_state == wdr_pkg::ST_LOAD) && (state != wdr_pkg::ST_LOAD);
      if (next_state == wdr_pkg::ST_LOAD && state != wdr_pkg::ST_LOAD) begin
        eepromMacOnly <= (state == wdr_pkg::ST_RUN);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phyPowerDown <= 1'b1;
    end else if (regsClear) begin
      phyPowerDown <= 1'b1;
    end else if (wrPm) begin
      phyPowerDown <= busReq.writeData[wdr_pkg::PM_PHY_DOWN];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tapReset <= 1'b0;
    end else begin
      tapReset <= !syncPins.tapResetN;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      readData <= 32'h0000_0000;
    end else begin
      readData <= 32'h0000_0000;
      if (busReq.read) begin
        unique case (busReq.addr)
          wdr_pkg::ADDR_HW_CONFIG:
            readData[4:0] <= {stickyBit, detachStatus, detachEnable, liteRequest, softPending};
          wdr_pkg::ADDR_POWER_MGMT:
            readData[7:0] <= {phyPowerDown, energyWakeEnable, lanWakeEnable, suspendSelect,
                              wakeSource, state == wdr_pkg::ST_RUN};
          wdr_pkg::ADDR_PIN7_CONFIG:  readData[6:0] <= pin7Config;
          wdr_pkg::ADDR_IRQ_STATUS:   readData[1:0] <= {phyIrq, pin7Status};
          wdr_pkg::ADDR_WAKE_CONTROL: readData[1:0] <= lanEnables;
          default:                    readData <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence softHoldStart;
    state != wdr_pkg::ST_SOFT_HOLD ##1 state == wdr_pkg::ST_SOFT_HOLD;
  endsequence

  a_unpowered_ignores_pin: assert property (
    state == wdr_pkg::ST_UNPOWERED && !syncPins.busPowerDetect
      |=> state == wdr_pkg::ST_UNPOWERED)
    else $error("External reset acted while unpowered.");

  a_soft_hold_length: assert property (
    softHoldStart |-> (state == wdr_pkg::ST_SOFT_HOLD) [*8])
    else $error("Soft reset hold ended too early.");

  a_soft_bit_clears: assert property (
    softHoldStart |-> ##[1:60] !softPending)
    else $error("Soft reset bit did not self-clear.");

  a_ext_hold_reset: assert property (
    state == wdr_pkg::ST_EXT_HOLD |-> chipReset && usbCoreReset ##1 phyPowerDown)
    else $error("External reset hold did not reset the chip.");

  a_lite_spares_usb: assert property (
    state == wdr_pkg::ST_LITE_HOLD |-> !usbCoreReset && usbPllEnable && !eepromLoad)
    else $error("Lite reset touched the USB side.");

  a_detach_pll_off: assert property (
    state == wdr_pkg::ST_DETACHED |-> !usbAttach && !usbPllEnable && suspendOnePower)
    else $error("Detached device still attached.");

  a_reattach_status: assert property (
    state == wdr_pkg::ST_DETACHED && next_state == wdr_pkg::ST_RUN
      |=> detachStatus ##1 usbAttach)
    else $error("Re-attach did not report detach status.");

  a_mac_clear_refused: assert property (
    macWakeEvent |=> wakeSource[1])
    else $error("Wake source bit 1 cleared while MAC wake asserted.");

  a_stale_pin7_wakes: assert property (
    usbSuspended && wakeCondition && !$past(wakeCondition && usbSuspended) |=> remoteWake)
    else $error("Remote wake not raised for armed wake condition.");

  a_usb_reset_mac_only: assert property (
    state == wdr_pkg::ST_RUN && usbBusReset && syncPins.externalResetN
      && syncPins.busPowerDetect |=> eepromLoad && eepromMacOnly && !usbCoreReset)
    else $error("USB reset did not reload MAC address only.");
endmodule
`default_nettype wire

/* File: wdr_pkg.sv */
`default_nettype none
package wdr_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_HW_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_POWER_MGMT = 8'h04;
  localparam logic [7:0] ADDR_PIN7_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_WAKE_CONTROL = 8'h10;
  // Field positions of hardware_config_reg.
  localparam int HW_SOFT_RESET = 0;
  localparam int HW_LITE_RESET = 1;
  localparam int HW_DETACH_ENABLE = 2;
  localparam int HW_DETACH_STATUS = 3;
  localparam int HW_STICKY = 4;
  // Field positions of power_mgmt_control.
  localparam int PM_READY = 0;
  localparam int PM_WAKE_SRC_LO = 1;
  localparam int PM_SUSPEND_LO = 3;
  localparam int PM_LAN_WAKE = 5;
  localparam int PM_ENERGY_WAKE = 6;
  localparam int PM_PHY_DOWN = 7;
  // Field positions of the pin 7 configuration register.
  localparam int P7_LINK_UP_WAKE = 0;
  localparam int P7_WAKE_ENABLE = 1;
  localparam int P7_POLARITY = 2;
  localparam int P7_ENABLE_N = 3;
  localparam int P7_DIRECTION = 4;
  localparam int P7_BUFFER = 5;
  localparam int P7_DETACH_WAKE = 6;
  // Field positions of irq_status_reg.
  localparam int IRQ_PIN7 = 0;
  localparam int IRQ_PHY = 1;
  // Values after reset.
  localparam logic [6:0] PIN7_CONFIG_RESET = 7'h08;
  localparam logic [1:0] SUSPEND_RESET = 2'h0;
  localparam logic [1:0] LAN_ENABLES_RESET = 2'h0;
  // Timing.
  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_TIME_NS = 22000000;
  localparam int POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int SOFT_TIME_NS = 2000;
  localparam int SOFT_CYCLES = SOFT_TIME_NS / CLK_PERIOD_NS;
  localparam int LITE_CYCLES = 4;
  localparam int COUNT_WIDTH = 20;
  // Pin synchroniser lanes.
  localparam int SYNC_WIDTH = 4;
  localparam logic [3:0] SYNC_RESET = 4'he;

  typedef enum logic [3:0] {
    ST_UNPOWERED,
    ST_POR_HOLD,
    ST_EXT_HOLD,
    ST_SOFT_HOLD,
    ST_LITE_HOLD,
    ST_LOAD,
    ST_RUN,
    ST_DETACHED
  } wdr_state_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] writeData;
    logic        write;
    logic        read;
  } wdr_bus_req_type;

  typedef struct packed {
    logic externalResetN;
    logic tapResetN;
    logic busPowerDetect;
    logic pin7;
  } wdr_pins_type;
endpackage
`default_nettype wire

/* File: wdr_pin_sync.sv */
`default_nettype none
// Three-stage synchroniser; a change is taken once stages two and three agree.
module wdr_pin_sync (
  // Clock and reset.
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  // Pins and their synchronised levels.
  input  wire logic [wdr_pkg::SYNC_WIDTH-1:0] pinIn,
  output var  logic [wdr_pkg::SYNC_WIDTH-1:0] pinOut
);
  logic [wdr_pkg::SYNC_WIDTH-1:0] stage1;
  logic [wdr_pkg::SYNC_WIDTH-1:0] stage2;
  logic [wdr_pkg::SYNC_WIDTH-1:0] stage3;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage1 <= wdr_pkg::SYNC_RESET;
      stage2 <= wdr_pkg::SYNC_RESET;
      stage3 <= wdr_pkg::SYNC_RESET;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pinOut <= wdr_pkg::SYNC_RESET;
    end else begin
      for (int i = 0; i < wdr_pkg::SYNC_WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          pinOut[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: wdr_host_model.sv */
`default_nettype none
// Host side: enters suspend on request and resumes on remote wake.
module wdr_host_model (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic reset,
  // Bench requests and device wake.
  input  wire logic sleepReq,
  input  wire logic outReq,
  input  wire logic busRstReq,
  input  wire logic remoteWake,
  // USB events.
  output var  logic usbSuspended,
  output var  logic goodOutPacket,
  output var  logic usbBusReset
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      usbSuspended <= 1'b0;
      goodOutPacket <= 1'b0;
      usbBusReset <= 1'b0;
    end else begin
      usbSuspended <= sleepReq | (usbSuspended & ~remoteWake);
      goodOutPacket <= outReq;
      usbBusReset <= busRstReq;
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] HWR = wdr_pkg::ADDR_HW_CONFIG;
  localparam logic [7:0] PMR = wdr_pkg::ADDR_POWER_MGMT;
  logic                     sys_clk, reset, phyLinkUp, macGoodFrame, macWakeEvent, eepromDone;
  logic                     remoteWake, usbAttach, usbPllEnable, suspendOnePower, chipReset;
  logic                     usbCoreReset, tapReset, eepromLoad, eepromMacOnly, phyPowerDown;
  logic                     usbSuspended, goodOutPacket, usbBusReset, phyIrq;
  logic [2:0]               hostReq;
  logic [31:0]              readData, d;
  wdr_pkg::wdr_bus_req_type busReq;
  wdr_pkg::wdr_pins_type    pins;
  int                       failures, checksDone, waited, cycles, loads;
  wdr_wake_detach_reset_control #(.PorCycles(100)) u_wdr_wake_detach_reset_control (
    .sys_clk, .reset, .busReq, .readData, .pins, .phyLinkUp, .phyIrq, .macGoodFrame,
    .macWakeEvent, .usbBusReset, .usbSuspended, .goodOutPacket, .eepromDone, .remoteWake,
    .usbAttach, .usbPllEnable, .suspendOnePower, .chipReset, .usbCoreReset, .tapReset,
    .eepromLoad, .eepromMacOnly, .phyPowerDown);
  wdr_host_model u_wdr_host_model (.sys_clk, .reset, .sleepReq(hostReq[0]),
    .outReq(hostReq[1]), .busRstReq(hostReq[2]), .remoteWake, .usbSuspended,
    .goodOutPacket, .usbBusReset);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    loads += int'(eepromLoad === 1'b1);
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (failures == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return remoteWake;
      1: return eepromLoad;
      2: return usbAttach;
      3: return chipReset;
      default: return tapReset;
    endcase
  endfunction
  task automatic wt(input int k, input logic v, input int lim);
    waited = 0;
    do begin
      @(posedge sys_clk);
      #1;
      waited++;
    end while (pick(k) !== v && waited < lim);
    ck({31'h0, pick(k)}, {31'h0, v});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    busReq <= '{a, w, 1'b1, 1'b0};
    @(posedge sys_clk);
    busReq.write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    busReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    busReq.read <= 1'b0;
    #1;
    ck(readData & m, e);
  endtask
  task automatic hreq(input logic [2:0] r);
    @(posedge sys_clk);
    hostReq <= r;
    @(posedge sys_clk);
    hostReq <= 3'h0;
  endtask
  task automatic boot(input logic macOnly, input int lim);
    wt(1, 1'b1, lim);
    ck({31'h0, eepromMacOnly}, {31'h0, macOnly});
    @(posedge sys_clk);
    eepromDone <= 1'b1;
    @(posedge sys_clk);
    eepromDone <= 1'b0;
    rd(PMR, 32'h81, 32'h81);
  endtask
  initial begin
    reset = 1'b1;
    busReq = '0;
    pins = 4'he;
    {phyIrq, phyLinkUp, macGoodFrame, macWakeEvent, eepromDone, hostReq} = 8'h0;
    void'($urandom(32'hd034));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    wt(3, 1'b1, 2);
    boot(1'b0, 300);
    wr(8'hf0, $urandom);
    rd(8'hf0, 32'hffffffff, 32'h0);
    wr(wdr_pkg::ADDR_PIN7_CONFIG, 32'h07);
    wr(wdr_pkg::ADDR_IRQ_STATUS, 32'h1);
    wr(PMR, 32'h0);
    hreq(3'h1);
    repeat ($urandom_range(9, 2)) @(posedge sys_clk);
    phyLinkUp <= 1'b1;
    wt(0, 1'b1, 6);
    rd(wdr_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h1);
    phyLinkUp <= 1'b0;
    hreq(3'h1);
    wt(0, 1'b1, 4);
    wr(wdr_pkg::ADDR_IRQ_STATUS, 32'h1);
    wr(wdr_pkg::ADDR_WAKE_CONTROL, 32'h0);
    wr(PMR, 32'h1c);
    hreq(3'h1);
    macGoodFrame <= 1'b1;
    @(posedge sys_clk);
    macGoodFrame <= 1'b0;
    wt(0, 1'b1, 6);
    rd(PMR, 32'h1e, 32'h1c);
    macWakeEvent <= 1'b1;
    wr(PMR, 32'h1c);
    rd(PMR, 32'h4, 32'h4);
    macWakeEvent <= 1'b0;
    wr(PMR, 32'h1c);
    rd(PMR, 32'h4, 32'h0);
    wr(PMR, 32'h4a);
    hreq(3'h1);
    phyIrq <= 1'b1;
    wt(0, 1'b1, 6);
    phyIrq <= 1'b0;
    rd(PMR, 32'h2, 32'h2);
    wr(PMR, 32'h2);
    rd(PMR, 32'h2, 32'h0);
    wr(HWR, 32'h04);
    wt(2, 1'b0, 4);
    ck({usbPllEnable, suspendOnePower}, 2'b01);
    repeat ($urandom_range(9, 2)) @(posedge sys_clk);
    phyLinkUp <= 1'b1;
    wt(2, 1'b1, 6);
    phyLinkUp <= 1'b0;
    rd(HWR, 32'h08, 32'h08);
    wr(HWR, 32'h11);
    repeat (5) @(posedge sys_clk);
    hreq(3'h2);
    wt(2, 1'b0, 4);
    boot(1'b0, 80);
    ck(waited inside {[wdr_pkg::SOFT_CYCLES-6:wdr_pkg::SOFT_CYCLES+4]}, 32'h1);
    rd(HWR, 32'h11, 32'h10);
    d = loads;
    wr(HWR, 32'h02);
    wt(3, 1'b1, 4);
    ck({usbCoreReset, usbAttach, usbPllEnable}, 3'b011);
    wt(3, 1'b0, 10);
    rd(PMR, 32'h1, 32'h1);
    ck(loads, d);
    wr(PMR, 32'h0);
    hreq(3'h4);
    boot(1'b1, 10);
    pins.externalResetN <= 1'b0;
    wt(3, 1'b1, 8);
    rd(PMR, 32'h1, 32'h0);
    pins.externalResetN <= 1'b1;
    boot(1'b0, 20);
    pins.busPowerDetect <= 1'b0;
    wt(2, 1'b0, 8);
    pins.busPowerDetect <= 1'b1;
    boot(1'b0, 30);
    pins.tapResetN <= 1'b0;
    wt(4, 1'b1, 8);
    ck({chipReset, usbAttach}, 2'b01);
    give_verdict();
  end
endmodule
`default_nettype wire
